// ---- bnvm_host.sv ----
// Host controller driving a bytewide nonvolatile memory over its pins
// Operation
// - Host holds strobes low for access time
// - Host holds write data stable through setup
// - Access then precharge, host holds precharge minimum
// - Host limits chip select low time
// - Host makes fresh chip-select fall per access
// - Host keeps chip select high in reset
// - Write strobe high during power cycles
`timescale 1ns/1ps
module bnvm_host
    import bnvm_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [bnvm_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [bnvm_pkg::DATA_W-1:0] req_wdata,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [bnvm_pkg::DATA_W-1:0]     rsp_rdata,
    output logic [bnvm_pkg::ADDR_W-1:0]     byte_address_lines,
    output logic                            chip_sel_b,
    output logic                            write_strobe_b,
    output logic                            out_drive_b,
    input  wire logic [bnvm_pkg::DATA_W-1:0] data_lines_in,
    output logic [bnvm_pkg::DATA_W-1:0]     data_lines_out,
    output logic                            data_lines_oe_b
);
    import bnvm_pkg::*;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    bnvm_state_e       state_q, state_d;
    logic              write_q;
    logic              req_ready_q, rsp_valid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic              ce_b_q, we_b_q, oe_b_q, doe_b_q;
    bnvm_timer_if      tif ();

    bnvm_timer u_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .tif   (tif)
    );

    wire take_req   = (state_q == ST_IDLE) && req_valid;
    wire access_end = (state_q == ST_ACCESS) && tif.done;
    wire pre_end    = (state_q == ST_PRECHARGE) && tif.done;

    // Same access count for read and write keeps timing identical
    // Loading the full access count keeps select low one cycle past the access
    // time, so read data has settled at the edge that samples it
    assign tif.load  = access_end || (state_q == ST_SETUP);
    assign tif.count = (state_q == ST_SETUP) ? CNT_W'(ACCESS_CYC) : CNT_W'(PRECHARGE_CYC - 1);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:      if (req_valid) state_d = ST_SETUP;
            ST_SETUP:     state_d = ST_ACCESS;
            ST_ACCESS:    if (tif.done) state_d = ST_PRECHARGE;
            ST_PRECHARGE: if (tif.done) state_d = ST_IDLE;
            default:      state_d = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Address and data are set up a cycle before chip select falls
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q  <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
        end
        else if (take_req)
        begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            write_q <= req_write;
        end
    end

    // Chip select high in reset and idle; one fall per access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ce_b_q <= 1'b1;
        else if (state_q == ST_SETUP)
            ce_b_q <= 1'b0;
        else if (access_end)
            ce_b_q <= 1'b1;
    end

    // Write strobe falls with chip select: chip-select controlled write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            we_b_q <= 1'b1;
        else if (state_q == ST_SETUP)
            we_b_q <= !write_q;
        else if (access_end)
            we_b_q <= 1'b1;
    end

    // Output drive only for reads; data bus driven only for writes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oe_b_q  <= 1'b1;
            doe_b_q <= 1'b1;
        end
        else if (state_q == ST_SETUP)
        begin
            oe_b_q  <= write_q;
            doe_b_q <= !write_q;
        end
        else if (access_end)
        begin
            oe_b_q  <= 1'b1;
            doe_b_q <= 1'b1;
        end
    end

    // Read data sampled at the end of access; no polling after writes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q     <= '0;
            rsp_valid_q <= 1'b0;
            req_ready_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q <= access_end;
            req_ready_q <= (state_d == ST_IDLE);
            if (access_end && !write_q)
                rdata_q <= data_lines_in;
        end
    end

    assign req_ready          = req_ready_q;
    assign rsp_valid          = rsp_valid_q;
    assign rsp_rdata          = rdata_q;
    assign byte_address_lines = addr_q;
    assign chip_sel_b         = ce_b_q;
    assign write_strobe_b     = we_b_q;
    assign out_drive_b        = oe_b_q;
    assign data_lines_out     = wdata_q;
    assign data_lines_oe_b    = doe_b_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_ce_fall;
        $fell(chip_sel_b);
    endsequence

    a_ce_low_access: assert property (@(posedge clk) disable iff (!rst_b)
        s_ce_fall |-> !chip_sel_b [*2] ##1 chip_sel_b)
        else $error("Chip select low time wrong");

    a_precharge_min: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(chip_sel_b) |-> chip_sel_b [*2])
        else $error("Precharge too short");

    a_we_with_ce: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(chip_sel_b) |-> write_strobe_b)
        else $error("Write strobe outlived chip select");

    a_no_contention: assert property (@(posedge clk) disable iff (!rst_b)
        !data_lines_oe_b |-> out_drive_b && !write_strobe_b)
        else $error("Data bus contention");

    a_wdata_stable: assert property (@(posedge clk) disable iff (!rst_b)
        !data_lines_oe_b && $past(!data_lines_oe_b) |-> $stable(data_lines_out))
        else $error("Write data changed");

    a_addr_stable: assert property (@(posedge clk) disable iff (!rst_b)
        !chip_sel_b && $past(!chip_sel_b) |-> $stable(byte_address_lines))
        else $error("Address changed during access");

    a_ce_max_low: assert property (@(posedge clk) disable iff (!rst_b)
        s_ce_fall |-> ##[1:8] chip_sel_b)
        else $error("Chip select held low too long");

    a_rsp_after: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(chip_sel_b) |-> rsp_valid)
        else $error("Response missing");

    a_idle_pins_high: assert property (@(posedge clk) disable iff (!rst_b)
        req_ready |-> chip_sel_b && write_strobe_b && out_drive_b && data_lines_oe_b)
        else $error("Memory pins active while idle");

    a_oe_read_only: assert property (@(posedge clk) disable iff (!rst_b)
        !out_drive_b |-> write_strobe_b && data_lines_oe_b && !chip_sel_b)
        else $error("Output drive outside a read");
endmodule : bnvm_host

// ---- bnvm_mem_model.sv ----
// Behavioural model of the bytewide nonvolatile memory on the host's pins
`timescale 1ns/1ps
module bnvm_mem_model
    import bnvm_pkg::*;
(
    input  wire logic [ADDR_W-1:0] byte_address_lines,
    input  wire logic              chip_sel_b,
    input  wire logic              write_strobe_b,
    input  wire logic              out_drive_b,
    input  wire logic [DATA_W-1:0] host_data,
    input  wire logic              host_oe_b,
    output logic [DATA_W-1:0]      data_lines,
    output int                     viol
);
    import bnvm_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    int                row_hits [0:1023];
    logic [ADDR_W-1:0] addr_q;
    logic              wr_q    = 1'b0;
    logic              ready_q = 1'b0;
    logic [DATA_W-1:0] last_q  = 8'h00;
    time               fall_t  = 0;
    time               rise_t  = 0;
    wire               dev_on;
    initial viol = 0;
    // Cycle starts only on a select fall; address is frozen until the next one
    always @(negedge chip_sel_b)
    begin
        addr_q = byte_address_lines;
        wr_q = !write_strobe_b;
        row_hits[byte_address_lines[ADDR_W-1:3]]++;
        if ($time - rise_t < PRECHARGE_MIN_TIME_NS) viol++;
        fall_t = $time;
        ready_q = 1'b0;
        #(ACCESS_TIME_NS) ready_q = 1'b1;
    end
    always @(negedge write_strobe_b) if (!chip_sel_b) wr_q = 1'b1;
    // Write lands at the first strobe rise and is usable at once
    always @(posedge chip_sel_b or posedge write_strobe_b)
    begin
        if (chip_sel_b) rise_t = $time;
        if (wr_q)
        begin
            if ($time - fall_t < ACCESS_TIME_NS) viol++;
            mem[addr_q] = host_data;
            wr_q = 1'b0;
        end
    end
    assign dev_on = !chip_sel_b && !out_drive_b && ready_q && !wr_q;
    always @(dev_on or host_oe_b) if (dev_on && !host_oe_b) viol++;
    always @(negedge dev_on) last_q = ~mem[addr_q];
    always @(posedge host_oe_b) last_q = ~host_data;
    // No pull on the bus: a released line shows the inverse of its last value
    assign data_lines = dev_on ? mem[addr_q] : (!host_oe_b ? host_data : last_q);
endmodule : bnvm_mem_model

// ---- bnvm_pkg.sv ----
// Package for the bytewide nonvolatile memory host controller
package bnvm_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACCESS_TIME_NS = 70;
    localparam int PRECHARGE_MIN_TIME_NS = 130;
    localparam int CE_LOW_MAX_NS = 10000;
    localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_CYC = (PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_LOW_MAX_CYC = CE_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACCESS, ST_END, ST_PRECHARGE} bnvm_state_e;
endpackage : bnvm_pkg

// ---- bnvm_timer.sv ----
// Down counter that times access and precharge phases
`timescale 1ns/1ps
module bnvm_timer
    import bnvm_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    bnvm_timer_if.tmr  tif
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= CNT_RESET;
        else if (tif.load)
            cnt_q <= tif.count;
        else if (cnt_q != CNT_RESET)
            cnt_q <= cnt_q - 8'h01;
    end

    // Done depends on the count alone: the sequencer builds its load from done,
    // so gating done with load would close a combinational loop
    assign tif.done = (cnt_q == CNT_RESET);
endmodule : bnvm_timer

// ---- bnvm_timer_if.sv ----
// Handshake between the sequencer and its cycle timer
`timescale 1ns/1ps
interface bnvm_timer_if;
    import bnvm_pkg::*;
    logic             load;
    logic [CNT_W-1:0] count;
    logic             done;
    modport ctrl (output load, output count, input done);
    modport tmr  (input load, input count, output done);
endinterface : bnvm_timer_if

// ---- bytewide_nv_memory_port_tb.sv ----
// Self-checking testbench for the memory host controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (a), (b)); end end
module bytewide_nv_memory_port_tb;
    import bnvm_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0, byte_address_lines;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, din, dout;
    logic req_ready, rsp_valid, chip_sel_b, write_strobe_b, out_drive_b, oe_b, cs_p = 1'b1;
    logic [15:0] lfsr_q = 16'h003f;
    logic [DATA_W-1:0] shadow [int];
    logic [ADDR_W-1:0] written [$];
    int num_errors = 0, n_checks = 0, viol, lo = 0, hi = 0;
    logic [ADDR_W-1:0] corners [4] = '{13'h0000, 13'h0007, 13'h0008, 13'h1fff};
    initial forever #(CLK_PERIOD_NS/2) clk = ~clk;
    bnvm_host DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .byte_address_lines(byte_address_lines), .chip_sel_b(chip_sel_b),
        .write_strobe_b(write_strobe_b), .out_drive_b(out_drive_b), .data_lines_in(din),
        .data_lines_out(dout), .data_lines_oe_b(oe_b));
    bnvm_mem_model mem_u (.byte_address_lines(byte_address_lines), .chip_sel_b(chip_sel_b),
        .write_strobe_b(write_strobe_b), .out_drive_b(out_drive_b), .host_data(dout),
        .host_oe_b(oe_b), .data_lines(din), .viol(viol));
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next
    task automatic do_op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 20) begin @(posedge clk); #1; k++; end
        req_valid = 1'b1; req_write = w; req_addr = a; req_wdata = d;
        @(posedge clk); #1;
        req_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 10) begin @(posedge clk); #1; k++; end
        `CHK(k, ACCESS_CYC + 2)
        if (w) begin shadow[a] = d; written.push_back(a); end
        else `CHK(rsp_rdata, shadow[a])
    endtask : do_op
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Pin timing watched at the falling edge, away from the launching edge
    always @(negedge clk) if (rst_b)
    begin
        if (chip_sel_b && !cs_p) `CHK(lo, ACCESS_CYC + 1)
        if (!chip_sel_b && cs_p) `CHK(hi >= PRECHARGE_CYC, 1'b1)
        if (!oe_b) `CHK(write_strobe_b, 1'b0)
        if (chip_sel_b) begin hi++; lo = 0; end else begin lo++; hi = 0; end
        cs_p = chip_sel_b;
    end
    initial begin #2000000; num_errors++; give_verdict(); end
    initial
    begin
        repeat (8) @(posedge clk);
        #1 `CHK(chip_sel_b, 1'b1)
        rst_b = 1'b1;
        foreach (corners[i]) begin lfsr_q = lfsr_next(lfsr_q); do_op(1'b1, corners[i], lfsr_q[7:0]); end
        foreach (corners[i]) do_op(1'b0, corners[i], 8'h00);
        $display("corner test done");
        for (int n = 0; n < 80; n++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            if (lfsr_q[0] || written.size() == 0) do_op(1'b1, lfsr_q[15:3], lfsr_q[10:3]);
            else do_op(1'b0, written[lfsr_q[15:8] % written.size()], 8'h00);
        end
        do_op(1'b1, 13'h0aaa, 8'h5a);
        do_op(1'b0, 13'h0aaa, 8'h00); // read right after write
        $display("random test done");
        @(posedge clk); #1 rst_b = 1'b0;
        #1 `CHK({chip_sel_b, req_ready}, 2'b10)
        @(posedge clk); #1 rst_b = 1'b1; cs_p = 1'b1;
        do_op(1'b0, corners[3], 8'h00);
        `CHK(viol, 0)
        $display("reset test done");
        give_verdict();
    end
endmodule : bytewide_nv_memory_port_tb
